// File: hdl/video_error_status_mask.v
// error status and mask register bank with summary pin
// assumes a host port giving address, read and write strobes on clk
// assumes checker pulses are on clk; pins are asynchronous
`include "error_status_map.vh"
module video_error_status_mask (
	// clock and reset
	input  wire                clk,
	input  wire                reset,
	// asynchronous pins
	input  wire                reset_test_n,
	input  wire                locked,
	input  wire                processing_bypass_n,
	// mode from device configuration
	input  wire                video_mode,
	input  wire                hd_mode,
	input  wire                slave_mode,
	// field and standard events
	input  wire                field_start,
	input  wire                standard_change,
	// checker pulses
	input  wire                active_start_err,
	input  wire                line_number_err,
	input  wire                luma_line_crc_err,
	input  wire                chroma_line_crc_err,
	input  wire                luma_checksum_err,
	input  wire                chroma_checksum_err,
	input  wire                picture_crc_err,
	input  wire                full_field_crc_err,
	input  wire                format_mismatch_err,
	// host port
	input  wire [`ADDR_W-1:0]  host_addr,
	input  wire                host_read,
	input  wire                host_write,
	input  wire [15:0]         host_wdata,
	output reg  [15:0]         host_rdata,
	// summary pin
	output reg                 data_error_n
);
	wire [2:0]  pins_sync;
	wire [15:0] raw_events;
	wire [15:0] set_events;
	wire        test_low;
	wire        lock_sync;
	wire        bypass_low;
	wire        partial_clear;
	wire        full_clear;
	wire        read_flags;
	wire [15:0] error_flags;
	reg  [15:0] error_mask;
	reg  [15:0] next_flags;
	reg         active_start_flag;
	reg         line_number_flag;
	reg         luma_line_crc_flag;
	reg         chroma_line_crc_flag;
	reg         luma_checksum_flag;
	reg         chroma_checksum_flag;
	reg         lock_loss_flag;
	reg         picture_crc_flag;
	reg         full_field_crc_flag;
	reg         format_mismatch_flag;

	// true when a strobe addresses the given register
	// shared by the read clear and the mask write decode
	function hits;
		input [`ADDR_W-1:0] addr;
		input [`ADDR_W-1:0] target;
		input               strobe;
		begin
			hits = strobe && (addr == target);
		end
	endfunction

	// word seen by the host for an address
	// unmapped addresses read as zero
	function [15:0] read_word;
		input [`ADDR_W-1:0] addr;
		input [15:0]        flags;
		input [15:0]        mask;
		begin
			case (addr)
				`ERROR_FLAGS_ADDR: read_word = flags;
				`ERROR_MASK_ADDR:  read_word = mask;
				default:           read_word = 16'h0000;
			endcase
		end
	endfunction

	// pins pass two flops before use
	pin_sync #(
		.WIDTH      (3)
	) u_sync (
		.clk        (clk),
		.reset      (reset),
		.async_in   ({reset_test_n, locked, processing_bypass_n}),
		.reset_value(3'h7),
		.sync_out   (pins_sync)
	);

	assign test_low   = ~pins_sync[2];
	assign lock_sync  = pins_sync[1];
	assign bypass_low = ~pins_sync[0] & slave_mode;

	// raw events in register bit order
	assign raw_events = {5'h00,
		format_mismatch_err,  // [R9]
		full_field_crc_err,   // [R10]
		picture_crc_err,      // [R11]
		1'b0,
		chroma_checksum_err,  // [R13]
		luma_checksum_err,    // [R14]
		1'b0,
		chroma_line_crc_err,  // [R15]
		luma_line_crc_err,    // [R16]
		line_number_err,      // [R17]
		active_start_err};    // [R18]

	error_event_gate u_gate (
		.video_mode (video_mode & ~bypass_low),
		.hd_mode    (hd_mode),
		.locked     (lock_sync),
		.raw_events (raw_events),
		.error_mask (error_mask),
		.set_events (set_events)
	);

	assign read_flags    = hits(host_addr, `ERROR_FLAGS_ADDR, host_read);
	assign full_clear    = field_start | read_flags; // [R3]
	assign partial_clear = standard_change | test_low | ~lock_sync | bypass_low; // [R4]

	// flag update, set wins over any clear
	always @*
	begin
		next_flags = error_flags;
		if (full_clear)
			next_flags = `ERROR_FLAGS_RESET; // [R3]
		if (partial_clear)
			next_flags = next_flags & (16'h0001 << `BIT_LOCK_LOSS); // [R4]
		next_flags = (next_flags | set_events) & `USED_BITS_MASK; // [R2] [R19]
	end

	// stored flags gathered in register bit order
	// unused bits read as zero
	assign error_flags = {5'h00,
		format_mismatch_flag,  // [R9]
		full_field_crc_flag,   // [R10]
		picture_crc_flag,      // [R11]
		lock_loss_flag,        // [R12]
		chroma_checksum_flag,  // [R13]
		luma_checksum_flag,    // [R14]
		1'b0,
		chroma_line_crc_flag,  // [R15]
		luma_line_crc_flag,    // [R16]
		line_number_flag,      // [R17]
		active_start_flag};    // [R18]

	// active video start timing flag
	// holds until the field starts, the host reads it or a partial clear occurs
	always @(posedge clk)
	begin
		if (reset)
			active_start_flag <= `FLAG_RESET; // [R19]
		else
			active_start_flag <= next_flags[`BIT_ACTIVE_START]; // [R18]
	end

	// line number flag, only set in high definition
	// standard definition gating is done in the event gate
	always @(posedge clk)
	begin
		if (reset)
			line_number_flag <= `FLAG_RESET; // [R19]
		else
			line_number_flag <= next_flags[`BIT_LINE_NUMBER]; // [R17]
	end

	// luma line crc flag, high definition only
	// one mismatch per line is enough to hold it
	always @(posedge clk)
	begin
		if (reset)
			luma_line_crc_flag <= `FLAG_RESET; // [R19]
		else
			luma_line_crc_flag <= next_flags[`BIT_LUMA_LINE_CRC]; // [R16]
	end

	// chroma line crc flag, high definition only
	// one mismatch per line is enough to hold it
	always @(posedge clk)
	begin
		if (reset)
			chroma_line_crc_flag <= `FLAG_RESET; // [R19]
		else
			chroma_line_crc_flag <= next_flags[`BIT_CHROMA_LN_CRC]; // [R15]
	end

	// luma ancillary checksum flag
	// runs in both definitions
	always @(posedge clk)
	begin
		if (reset)
			luma_checksum_flag <= `FLAG_RESET; // [R19]
		else
			luma_checksum_flag <= next_flags[`BIT_LUMA_CHECKSUM]; // [R14]
	end

	// chroma ancillary checksum flag
	// runs in both definitions
	always @(posedge clk)
	begin
		if (reset)
			chroma_checksum_flag <= `FLAG_RESET; // [R19]
		else
			chroma_checksum_flag <= next_flags[`BIT_CHROMA_CHKSUM]; // [R13]
	end

	// lock loss flag, follows the synced lock pin
	// survives the partial clears, re-set while unlocked
	always @(posedge clk)
	begin
		if (reset)
			lock_loss_flag <= `FLAG_RESET; // [R19]
		else
			lock_loss_flag <= next_flags[`BIT_LOCK_LOSS]; // [R12]
	end

	// active picture crc flag, standard definition only
	// covers either field of the frame
	always @(posedge clk)
	begin
		if (reset)
			picture_crc_flag <= `FLAG_RESET; // [R19]
		else
			picture_crc_flag <= next_flags[`BIT_PICTURE_CRC]; // [R11]
	end

	// full field crc flag, standard definition only
	// covers either field of the frame
	always @(posedge clk)
	begin
		if (reset)
			full_field_crc_flag <= `FLAG_RESET; // [R19]
		else
			full_field_crc_flag <= next_flags[`BIT_FULL_FIELD_CRC]; // [R10]
	end

	// format mismatch flag from payload identifier compare
	// a stale packet can set it until the standard settles
	always @(posedge clk)
	begin
		if (reset)
			format_mismatch_flag <= `FLAG_RESET; // [R19]
		else
			format_mismatch_flag <= next_flags[`BIT_FORMAT_MISMATCH]; // [R9]
	end

	// mask register, writes elsewhere are ignored
	always @(posedge clk)
	begin
		if (reset)
			error_mask <= `ERROR_MASK_RESET; // [R6]
		else if (hits(host_addr, `ERROR_MASK_ADDR, host_write))
			error_mask <= host_wdata & `USED_BITS_MASK; // [R5] [R6]
	end

	// read data registered, one cycle after strobe
	always @(posedge clk)
	begin
		if (reset)
			host_rdata <= 16'h0000;
		else if (host_read)
			host_rdata <= read_word(host_addr, error_flags, error_mask); // [R2]
	end

	// active-low OR of stored flags, masked types never stored
	always @(posedge clk)
	begin
		if (reset)
			data_error_n <= 1'b1; // [R8]
		else
			data_error_n <= ~(|next_flags); // [R7] [R8]
	end
endmodule // video_error_status_mask

// File: hdl/error_status_map.vh
// constants for the video error status and mask bank
// assumes a host port that addresses 16-bit registers by index
// Operation
// R1: non-video modes disable all checks except lock
// R2: status register at 001h, one flag each
// R3: clear on field start or host read
// R4: clear all but lock on listed conditions
// R5: host mask, one bit per error type
// R6: mask resets to zero, high disables type
// R7: summary output is OR of flags
// R8: summary rests high, low on unmasked error
// R9: bit 10 flags format mismatch
// R10: SD full field CRC mismatch flag
// R11: SD active picture CRC mismatch flag
// R12: lock loss flag while lock low
// R13: chroma ancillary checksum error flag
// R14: luma ancillary checksum error flag
// R15: HD chroma line CRC mismatch flag
// R16: HD luma line CRC mismatch flag
// R17: HD line number mismatch flag
// R18: active video start timing error flag
// R19: bits 9,8,7,6,5 hold fixed flags; code holds bits 15:11 and 4 at zero, bits 9:5 are live flags
// R20: masked type sets no flag, no summary
`ifndef ERROR_STATUS_MAP_VH
`define ERROR_STATUS_MAP_VH
`define ADDR_W             12
`define ERROR_FLAGS_ADDR   12'h001
`define ERROR_MASK_ADDR    12'h002
`define ERROR_FLAGS_RESET  16'h0000
`define ERROR_MASK_RESET   16'h0000
`define FLAG_RESET         1'b0
`define BIT_ACTIVE_START   0
`define BIT_LINE_NUMBER    1
`define BIT_LUMA_LINE_CRC  2
`define BIT_CHROMA_LN_CRC  3
`define BIT_LUMA_CHECKSUM  5
`define BIT_CHROMA_CHKSUM  6
`define BIT_LOCK_LOSS      7
`define BIT_PICTURE_CRC    8
`define BIT_FULL_FIELD_CRC 9
`define BIT_FORMAT_MISMATCH 10
`define USED_BITS_MASK     16'h07EF
`endif

// File: hdl/pin_sync.v
// two-flop synchroniser for a bundle of asynchronous level inputs
// assumes inputs are levels that stay stable for several clocks
module pin_sync #(
	parameter WIDTH = 1
) (
	// clock and reset
	input  wire             clk,
	input  wire             reset,
	// level in and out
	input  wire [WIDTH-1:0] async_in,
	input  wire [WIDTH-1:0] reset_value,
	output reg  [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] stage1;

	// first stage feeds only the second
	always @(posedge clk)
	begin
		if (reset)
		begin
			stage1   <= reset_value;
			sync_out <= reset_value;
		end
		else
		begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule // pin_sync

// File: hdl/error_event_gate.v
// qualifies raw error events by operating mode, video rate and mask
// assumes raw events are one-cycle pulses from same-clock checkers
`include "error_status_map.vh"
module error_event_gate (
	// mode inputs
	input  wire        video_mode,
	input  wire        hd_mode,
	input  wire        locked,
	// raw events and mask
	input  wire [15:0] raw_events,
	input  wire [15:0] error_mask,
	// qualified events
	output wire [15:0] set_events
);
	reg [15:0] allowed;

	// which types may be detected now
	always @*
	begin
		allowed = `USED_BITS_MASK;
		if (!video_mode)
			allowed = 16'h0000; // [R1]
		if (hd_mode)
		begin
			allowed[`BIT_FULL_FIELD_CRC] = 1'b0; // [R10]
			allowed[`BIT_PICTURE_CRC]    = 1'b0; // [R11]
		end
		else
		begin
			allowed[`BIT_CHROMA_LN_CRC]  = 1'b0; // [R15]
			allowed[`BIT_LUMA_LINE_CRC]  = 1'b0; // [R16]
			allowed[`BIT_LINE_NUMBER]    = 1'b0; // [R17]
		end
		allowed[`BIT_LOCK_LOSS] = 1'b1; // lock check always runs [R1]
	end

	// lock loss is a level from the lock pin, not a pulse [R12]
	assign set_events = ((raw_events & ~(16'h0001 << `BIT_LOCK_LOSS))
		| ({15'h0000, ~locked} << `BIT_LOCK_LOSS))
		& allowed & ~error_mask; // [R20] [R5]
endmodule // error_event_gate

// File: verif/video_error_status_mask_sva.sv
// port assertions for the error status and mask bank
// assumes it is bound to video_error_status_mask
`include "error_status_map.vh"
module status_checker (
	input wire logic               clk,
	input wire logic               reset,
	input wire logic               locked,
	input wire logic               video_mode,
	input wire logic               field_start,
	input wire logic [`ADDR_W-1:0] host_addr,
	input wire logic               host_read,
	input wire logic [15:0]        host_rdata,
	input wire logic               data_error_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// port checks
	a_reset_idle: assert property ($fell(reset) |-> data_error_n && host_rdata == 0)
		else $error("reset values wrong");
	a_reserved_zero: assert property (host_rdata[15:11] == 5'h00 && !host_rdata[4])
		else $error("unused bits set");
	a_rdata_hold: assert property (!host_read |=> $stable(host_rdata))
		else $error("read data moved");
	a_unmapped_zero: assert property (host_read && host_addr == 12'h000 |=> host_rdata == 0)
		else $error("unmapped read not zero");
	a_summary_match: assert property (host_read && host_addr == 12'h001
		|=> (host_rdata != 0) == !$past(data_error_n))
		else $error("summary disagrees with flags");
	a_lock_flag: assert property (!locked [*4] |-> !data_error_n)
		else $error("lock loss not shown");
	a_nonvideo_quiet: assert property (locked [*3] ##0 (data_error_n && !video_mode)
		|=> data_error_n)
		else $error("check active outside video");
	a_field_clear: assert property (locked [*3] ##0 (field_start && !video_mode)
		|=> data_error_n)
		else $error("field start left flags");
	c_read: cover property (host_read && host_addr == 12'h001);
	c_error: cover property (!data_error_n);
	c_field: cover property (field_start);
endmodule // status_checker

bind video_error_status_mask status_checker chk (.clk(clk), .reset(reset), .locked(locked),
	.video_mode(video_mode), .field_start(field_start), .host_addr(host_addr),
	.host_read(host_read), .host_rdata(host_rdata), .data_error_n(data_error_n));

// File: verif/host_model.sv
// host processor model for the register port
// assumes strobes are sampled on the rising clk edge
module host_model (
	input wire logic        clk,
	output logic [11:0]     host_addr,
	output logic            host_read,
	output logic            host_write,
	output logic [15:0]     host_wdata,
	input wire logic [15:0] host_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		host_addr = 12'h000;
		host_read = 1'b0;
		host_write = 1'b0;
		host_wdata = 16'h0000;
	end
	// one write strobe, data scrambled once released
	task automatic wr(input logic [11:0] a, input logic [15:0] x);
		@(posedge clk);
		host_addr <= a;
		host_wdata <= x;
		host_write <= 1'b1;
		@(posedge clk);
		host_write <= 1'b0;
		host_wdata <= ~x;
	endtask
	// one read strobe, data valid after the sampling edge
	task automatic rd(input logic [11:0] a, output logic [15:0] x);
		@(posedge clk);
		host_addr <= a;
		host_read <= 1'b1;
		@(posedge clk);
		host_read <= 1'b0;
		@(posedge clk);
		x = host_rdata;
	endtask
endmodule // host_model

// File: verif/testbench.sv
// self-checking bench for the error status and mask bank
// assumes the host model drives the register port
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fails++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, reset, vm, hd;
	logic [4:0]  clr;
	logic [15:0] ev, d;
	logic [11:0] host_addr;
	logic        host_read, host_write, data_error_n;
	logic [15:0] host_wdata, host_rdata;
	int          fails, checked, cyc;
	int          bits[9] = '{0, 1, 2, 3, 5, 6, 8, 9, 10};
	host_model host (.clk(clk), .host_addr(host_addr), .host_read(host_read),
		.host_write(host_write), .host_wdata(host_wdata), .host_rdata(host_rdata));
	video_error_status_mask uut (.clk(clk), .reset(reset), .reset_test_n(!clr[0]),
		.locked(!clr[3]), .processing_bypass_n(!clr[1]), .video_mode(vm), .hd_mode(hd),
		.slave_mode(1'b1), .field_start(clr[4]), .standard_change(clr[2]),
		.active_start_err(ev[0]), .line_number_err(ev[1]), .luma_line_crc_err(ev[2]),
		.chroma_line_crc_err(ev[3]), .luma_checksum_err(ev[5]), .chroma_checksum_err(ev[6]),
		.picture_crc_err(ev[8]), .full_field_crc_err(ev[9]), .format_mismatch_err(ev[10]),
		.host_addr(host_addr), .host_read(host_read), .host_write(host_write),
		.host_wdata(host_wdata), .host_rdata(host_rdata), .data_error_n(data_error_n));
	// verdict and end of run
	task tally_and_finish;
		if (fails == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// one-cycle checker event, then let its edge land
	task pulse(input logic [15:0] x);
		@(posedge clk);
		ev <= x;
		@(posedge clk);
		ev <= 16'h0000;
		@(posedge clk);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fails++;
			tally_and_finish;
		end
	end
	initial
	begin
		reset = 1'b1;
		ev = 16'h0000;
		clr = 5'h00;
		vm = 1'b1;
		hd = 1'b0;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		host.rd(12'h001, d);
		`CHK("flags", 16'h0000, d)
		host.rd(12'h002, d);
		`CHK("mask", 16'h0000, d)
		`CHK("summary", 1'b1, data_error_n)
		host.rd(12'h000, d);
		`CHK("unmapped", 16'h0000, d)
		foreach (bits[i])
		begin
			hd <= bits[i] inside {1, 2, 3};
			pulse(16'h0001 << bits[i]);
			`CHK("summary", 1'b0, data_error_n)
			host.rd(12'h001, d);
			`CHK("flags", 16'h0001 << bits[i], d)
			host.rd(12'h001, d);
			`CHK("flags", 16'h0000, d)
		end
		vm <= 1'b0;
		pulse(16'h076F);
		`CHK("summary", 1'b1, data_error_n)
		host.rd(12'h001, d);
		`CHK("flags", 16'h0000, d)
		vm <= 1'b1;
		host.wr(12'h002, 16'h0400);
		pulse(16'h0400);
		`CHK("summary", 1'b1, data_error_n)
		host.rd(12'h001, d);
		`CHK("flags", 16'h0000, d)
		host.wr(12'h002, 16'h0000);
		for (int k = 0; k < 5; k++)
		begin
			pulse(16'h0001);
			clr <= 5'h01 << k;
			vm <= k != 4;
			repeat (4) @(posedge clk);
			host.rd(12'h001, d);
			`CHK("flags", k == 3 ? 16'h0080 : 16'h0000, d)
			clr <= 5'h00;
			vm <= 1'b1;
			repeat (4) @(posedge clk);
			host.rd(12'h001, d);
		end
		tally_and_finish;
	end
endmodule // testbench
